// File: rtl/dlt_target.sv
// Die link target: decodes link frames into analog register accesses
//
// Summary of operation
// - Write: command, address, byte or word data
// - Read: command, address, target returns register data
// - Target drives read data after address beat
// - Blocking reads/writes and non-blocking writes supported
// - Eight-bit address reaches 256 byte space
// - Eight-bit bidirectional data path both ways
// - Resynchronise when link clock stays low for RESYNC_CYC cycles
// - Status byte with error and end-of-transfer ack
// - Interrupt requests merged onto one output
// - Target disabled in sleep and stop
// - Interrupt line wakes sleeping initiator in stop
// - Wake command recognised during stop mode
// - Clock input, data bidirectional, interrupt output
// - Sleep pulls all data pins low
// - Initiator windows 0x0200 blocking, 0x0300 non-blocking
`timescale 1ns/1ps
`default_nettype none
module dlt_target
  import dlt_pkg::*;
#(
  parameter int unsigned IRQ_N      = 4,
  parameter int unsigned RESYNC_CYC = LINK_RESYNC_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  dlt_link_if.target            link,
  input  wire dlt_mode_t        mode_i,
  input  wire logic [IRQ_N-1:0] irq_i,
  input  wire logic [15:0]      reg_rdata_i,
  input  wire logic             reg_err_i,
  output logic [7:0]            reg_addr_o,
  output logic [15:0]           reg_wdata_o,
  output logic                  reg_word_o,
  output logic                  reg_wr_o,
  output logic                  reg_rd_o,
  output logic                  wake_o
);

  // ==========================================================
  // Parameter check
  generate
    if (IRQ_N < 1 || RESYNC_CYC < 2 || RESYNC_CYC > 65535) begin : g_bad
      $error("dlt_target: unsupported IRQ_N or RESYNC_CYC");
    end
  endgenerate

  typedef enum logic [1:0] {
    DLT_T_IDLE = 2'b00,
    DLT_T_REQ  = 2'b01,
    DLT_T_RESP = 2'b11,
    DLT_T_DONE = 2'b10
  } dlt_tstate_t;

  dlt_tstate_t st_q;
  logic        clk_s1_q;
  logic        clk_s2_q;
  logic        clk_s3_q;
  logic [7:0]  dat_s1_q;
  logic [7:0]  dat_s2_q;
  logic [15:0] low_cnt_q;
  logic [2:0]  beat_q;
  logic [7:0]  cmd_q;
  logic [7:0]  addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        err_q;
  logic        wr_q;
  logic        rd_q;
  logic        wake_q;
  logic        frame_q;
  logic [7:0]  tx_q;
  logic        oe_q;
  logic        int_q;
  logic        rise;
  logic        fall;
  logic        resync;
  logic        normal;
  logic        fire;
  logic [2:0]  n_req;
  logic [2:0]  n_all;

  // ==========================================================
  // Link clock and data sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_s1_q <= 1'h0;
      clk_s2_q <= 1'h0;
      clk_s3_q <= 1'h0;
      dat_s1_q <= DATA_RST;
      dat_s2_q <= DATA_RST;
    end else begin
      clk_s1_q <= link.link_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= link.link_data;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign rise   = clk_s2_q & ~clk_s3_q;
  assign fall   = ~clk_s2_q & clk_s3_q;
  assign normal = (mode_i == DLT_MODE_NORMAL);
  assign n_req  = dlt_req_beats(cmd_q);
  assign n_all  = dlt_all_beats(cmd_q);

  // A quiet link clock ends any frame, so the next rise is a command
  always_ff @(posedge clk_i) begin
    if (rst_i || clk_s2_q) begin
      low_cnt_q <= 16'h0000;
    end else if (!resync) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  assign resync = !clk_s2_q && (low_cnt_q == 16'(RESYNC_CYC));

  // ==========================================================
  // Frame sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i || !normal || resync) begin
      st_q   <= DLT_T_IDLE;
      beat_q <= 3'h0;
      cmd_q  <= 8'h00;
    end else begin
      case (st_q)
        DLT_T_IDLE: begin
          if (rise) begin
            cmd_q  <= dat_s2_q;
            beat_q <= 3'h1;
            st_q   <= (dlt_req_beats(dat_s2_q) == 3'h1) ? DLT_T_DONE
                                                         : DLT_T_REQ;
          end
        end
        DLT_T_REQ: begin
          if (rise) begin
            beat_q <= beat_q + 3'h1;
            if (beat_q + 3'h1 == n_req) begin
              st_q <= (n_all == n_req) ? DLT_T_DONE : DLT_T_RESP;
            end
          end
        end
        DLT_T_RESP: begin
          if (rise) begin
            beat_q <= beat_q + 3'h1;
          end else if (fall && beat_q == n_all) begin
            st_q <= DLT_T_DONE;
          end
        end
        DLT_T_DONE: st_q <= DLT_T_DONE; // Held until the link goes quiet
        default: begin
          st_q <= DLT_T_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Register access toward the analog die
  assign fire = normal && !resync && (st_q == DLT_T_REQ) && rise &&
                (beat_q + 3'h1 == n_req);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q  <= 8'h00;
      wdata_q <= 16'h0000;
    end else if (normal && st_q == DLT_T_REQ && rise) begin
      case (beat_q)
        3'h1:    addr_q        <= dat_s2_q;
        3'h2:    wdata_q[7:0]  <= dat_s2_q;
        3'h3:    wdata_q[15:8] <= dat_s2_q;
        default: addr_q        <= addr_q;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
    end else begin
      wr_q <= fire && dlt_cmd_valid(cmd_q) && cmd_q[CMD_WR_BIT];
      rd_q <= fire && dlt_cmd_valid(cmd_q) && !cmd_q[CMD_WR_BIT];
    end
  end
  // Answers are taken in the strobe cycle, long before the reply beat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q   <= 1'h0;
      rdata_q <= 16'h0000;
    end else if (fire) begin
      err_q <= !dlt_cmd_valid(cmd_q);
    end else if (wr_q || rd_q) begin
      err_q <= reg_err_i;
      if (rd_q) begin
        rdata_q <= reg_rdata_i;
      end
    end
  end

  // ==========================================================
  // Reply beats: read data low byte first, then status
  function automatic logic [7:0] resp_byte(input logic [2:0] idx);
    logic [7:0] s;
    s = 8'h00;
    s[ST_EOT_BIT] = 1'h1;
    s[ST_ERR_BIT] = err_q;
    s[ST_OK_BIT]  = !err_q;
    s[ST_WR_BIT]  = cmd_q[CMD_WR_BIT];
    if (!cmd_q[CMD_WR_BIT] && idx == 3'h0) return rdata_q[7:0];
    if (!cmd_q[CMD_WR_BIT] && cmd_q[CMD_WORD_BIT] && idx == 3'h1) begin
      return rdata_q[15:8];
    end
    return s;
  endfunction

  // Drive from a falling edge so the initiator has released the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= DATA_RST;
      oe_q <= 1'h0;
    end else if (mode_i == DLT_MODE_SLEEP) begin
      tx_q <= 8'h00;
      oe_q <= 1'h1;
    end else if (!normal || resync) begin
      oe_q <= 1'h0;
    end else if (st_q == DLT_T_RESP && fall) begin
      if (beat_q == n_all) begin
        oe_q <= 1'h0;
      end else begin
        tx_q <= resp_byte(beat_q - n_req);
        oe_q <= 1'h1;
      end
    end
  end

  // ==========================================================
  // Stop mode wake and interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i || resync) begin
      frame_q <= 1'h0;
    end else if (rise) begin
      frame_q <= 1'h1;
    end
  end
  // Only the first beat after a quiet clock can be a wake command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= (mode_i == DLT_MODE_STOP) && rise && !frame_q &&
                (dat_s2_q[7:4] == CMD_TAG) &&
                dat_s2_q[CMD_WAKE_BIT];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_q <= 1'h0;
    end else begin
      int_q <= (mode_i != DLT_MODE_SLEEP) && (|irq_i);
    end
  end
  assign link.tgt_data = tx_q;
  assign link.tgt_oe   = oe_q;
  assign link.link_int = int_q;
  assign reg_addr_o    = addr_q;
  assign reg_wdata_o   = wdata_q;
  assign reg_word_o    = cmd_q[CMD_WORD_BIT];
  assign reg_wr_o      = wr_q;
  assign reg_rd_o      = rd_q;
  assign wake_o        = wake_q;

endmodule // dlt_target
`default_nettype wire

// File: rtl/dlt_pkg.sv
// Shared constants, types and beat decoding for the die link
package dlt_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int unsigned LINK_HALF_NS = 40;
  localparam int unsigned LINK_HALF_CYC =
    (LINK_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESYNC_NS    = 200;
  localparam int unsigned LINK_RESYNC_CYC =
    (RESYNC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_NS       = 300;
  localparam int unsigned LINK_GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Command byte: tag in the high nibble, flags below
  localparam logic [3:0] CMD_TAG      = 4'ha;
  localparam int unsigned CMD_WR_BIT   = 0;
  localparam int unsigned CMD_WORD_BIT = 1;
  localparam int unsigned CMD_NB_BIT   = 2;
  localparam int unsigned CMD_WAKE_BIT = 3;

  // Status byte returned as the last beat of a blocking frame
  localparam int unsigned ST_OK_BIT  = 0;
  localparam int unsigned ST_WR_BIT  = 1;
  localparam int unsigned ST_ERR_BIT = 6;
  localparam int unsigned ST_EOT_BIT = 7;

  // Initiator address windows, upper byte of the global address
  localparam logic [7:0] WIN_BLOCK_PAGE = 8'h02;
  localparam logic [7:0] WIN_NB_PAGE    = 8'h03;

  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    DLT_MODE_NORMAL = 2'h0,
    DLT_MODE_SLEEP  = 2'h1,
    DLT_MODE_STOP   = 2'h2
  } dlt_mode_t;

  // ==========================================================
  // Beat counts: command, address, then data low byte first
  function automatic logic [2:0] dlt_req_beats(input logic [7:0] cmd);
    if (cmd[CMD_WAKE_BIT]) return 3'h1;
    if (cmd[CMD_WR_BIT]) return cmd[CMD_WORD_BIT] ? 3'h4 : 3'h3;
    return 3'h2;
  endfunction

  function automatic logic [2:0] dlt_all_beats(input logic [7:0] cmd);
    logic [2:0] n;
    n = dlt_req_beats(cmd);
    if (cmd[CMD_WAKE_BIT] || cmd[CMD_NB_BIT]) return n;
    if (!cmd[CMD_WR_BIT]) return n + (cmd[CMD_WORD_BIT] ? 3'h3 : 3'h2);
    return n + 3'h1;
  endfunction

  function automatic logic dlt_cmd_valid(input logic [7:0] cmd);
    return (cmd[7:4] == CMD_TAG) && !cmd[CMD_WAKE_BIT] &&
           !(cmd[CMD_NB_BIT] && !cmd[CMD_WR_BIT]);
  endfunction

endpackage

// File: rtl/dlt_link_if.sv
// Die link wires between initiator and target
`timescale 1ns/1ps
`default_nettype none
interface dlt_link_if;
  logic       link_clk;
  logic       link_int;
  logic [7:0] tgt_data;
  logic       tgt_oe;
  logic [7:0] ini_data;
  logic       ini_oe;
  logic [7:0] link_data;

  // Pull-downs hold the data pins low when nobody drives
  assign link_data = tgt_oe ? tgt_data : (ini_oe ? ini_data : 8'h00);

  modport target (
    input  link_clk,
    input  link_data,
    output tgt_data,
    output tgt_oe,
    output link_int
  );
  modport initiator (
    output link_clk,
    input  link_data,
    output ini_data,
    output ini_oe,
    input  link_int
  );
endinterface // dlt_link_if
`default_nettype wire

// File: rtl/dlt_initiator.sv
// Die link initiator: turns windowed accesses into link frames
`timescale 1ns/1ps
`default_nettype none
module dlt_initiator
  import dlt_pkg::*;
#(
  parameter int unsigned HALF_CYC = LINK_HALF_CYC,
  parameter int unsigned GAP_CYC  = LINK_GAP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  dlt_link_if.initiator    link,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic        req_word_i,
  input  wire logic        req_wake_i,
  input  wire logic [15:0] req_gaddr_i,
  input  wire logic [15:0] req_wdata_i,
  output logic             req_ready_o,
  output logic             done_o,
  output logic             done_err_o,
  output logic [15:0]      done_rdata_o,
  output logic [7:0]       done_status_o,
  output logic             irq_o
);

  // ==========================================================
  // Reply sampling needs four cycles of half period
  generate
    if (HALF_CYC < 4 || HALF_CYC > 127 || GAP_CYC <= LINK_RESYNC_CYC ||
        GAP_CYC > 65535) begin : g_bad
      $error("dlt_initiator: unsupported HALF_CYC or GAP_CYC");
    end
  endgenerate

  typedef enum logic [1:0] {
    DLT_I_IDLE = 2'b00,
    DLT_I_RUN  = 2'b01,
    DLT_I_GAP  = 2'b11
  } dlt_istate_t;

  localparam logic [7:0] PH_RISE = 8'(HALF_CYC - 1);
  localparam logic [7:0] PH_END  = 8'(2 * HALF_CYC - 1);

  dlt_istate_t st_q;
  logic [7:0]  phase_q;
  logic [15:0] gap_q;
  logic [2:0]  beat_q;
  logic [2:0]  nreq_q;
  logic [2:0]  nall_q;
  logic [7:0]  tx_q [4];
  logic [7:0]  rx_q [2];
  logic [7:0]  rx_s1_q;
  logic [7:0]  rx_s2_q;
  logic        int_s1_q;
  logic        int_s2_q;
  logic        clk_q;
  logic [7:0]  dat_q;
  logic        oe_q;
  logic        ready_q;
  logic        done_q;
  logic        err_q;
  logic [15:0] rdata_q;
  logic [7:0]  status_q;
  logic        rd_word_q;
  logic        rd_q;
  logic        accept;
  logic        bad;
  logic        end_beat;
  logic [7:0]  cmd;

  // ==========================================================
  // Request decode: page 0x02 blocking, page 0x03 posted writes
  assign bad = !req_wake_i &&
               !((req_gaddr_i[15:8] == WIN_BLOCK_PAGE) ||
                 ((req_gaddr_i[15:8] == WIN_NB_PAGE) && req_write_i));

  always_comb begin
    cmd = {CMD_TAG, 4'h0};
    cmd[CMD_WAKE_BIT] = req_wake_i;
    cmd[CMD_WR_BIT]   = req_write_i && !req_wake_i;
    cmd[CMD_WORD_BIT] = req_word_i && !req_wake_i;
    cmd[CMD_NB_BIT]   = (req_gaddr_i[15:8] == WIN_NB_PAGE) && !req_wake_i;
  end

  assign accept   = req_valid_i && ready_q;
  assign end_beat = (st_q == DLT_I_RUN) && (phase_q == PH_END);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_q  <= DATA_RST;
      rx_s2_q  <= DATA_RST;
      int_s1_q <= 1'h0;
      int_s2_q <= 1'h0;
    end else begin
      rx_s1_q  <= link.link_data;
      rx_s2_q  <= rx_s1_q;
      int_s1_q <= link.link_int;
      int_s2_q <= int_s1_q;
    end
  end

  // ==========================================================
  // Frame engine; data is loaded at frame start with the clock low and otherwise changes only as the link clock falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= DLT_I_IDLE;
      phase_q <= 8'h00;
      gap_q   <= 16'h0000;
      beat_q  <= 3'h0;
      clk_q   <= 1'h0;
      dat_q   <= DATA_RST;
      oe_q    <= 1'h0;
    end else begin
      case (st_q)
        DLT_I_IDLE: begin
          if (accept && !bad) begin
            st_q      <= DLT_I_RUN;
            phase_q   <= 8'h00;
            beat_q    <= 3'h0;
            nreq_q    <= dlt_req_beats(cmd);
            nall_q    <= dlt_all_beats(cmd);
            tx_q[0]   <= cmd;
            tx_q[1]   <= req_gaddr_i[7:0];
            tx_q[2]   <= req_wdata_i[7:0];
            tx_q[3]   <= req_wdata_i[15:8];
            dat_q     <= cmd;
            oe_q      <= 1'h1;
          end
        end
        DLT_I_RUN: begin
          phase_q <= phase_q + 8'h01;
          if (phase_q == PH_RISE) begin
            clk_q <= 1'h1;
          end
          if (end_beat) begin
            clk_q   <= 1'h0;
            phase_q <= 8'h00;
            beat_q  <= beat_q + 3'h1;
            if (beat_q + 3'h1 == nall_q) begin
              st_q  <= DLT_I_GAP;
              gap_q <= 16'h0000;
              oe_q  <= 1'h0;
            end else if (beat_q + 3'h1 < nreq_q) begin
              dat_q <= tx_q[2'(beat_q + 3'h1)];
              oe_q  <= 1'h1;
            end else begin
              oe_q <= 1'h0;
            end
          end
        end
        DLT_I_GAP: begin
          gap_q <= gap_q + 16'h0001;
          if (gap_q == 16'(GAP_CYC - 1)) begin
            st_q <= DLT_I_IDLE;
          end
        end
        default: begin
          st_q <= DLT_I_IDLE;
        end
      endcase
    end
  end

  // Reply beats are sampled at the end of their high phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_q[0] <= 8'h00;
      rx_q[1] <= 8'h00;
    end else if (end_beat && beat_q >= nreq_q && beat_q - nreq_q < 3'h2) begin
      rx_q[1'(beat_q - nreq_q)] <= rx_s2_q;
    end
  end

  // ==========================================================
  // Completion: posted writes, wakes and refused requests finish at once, others on status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q   <= 1'h0;
      done_q    <= 1'h0;
      err_q     <= 1'h0;
      rdata_q   <= 16'h0000;
      status_q  <= 8'h00;
      rd_q      <= 1'h0;
      rd_word_q <= 1'h0;
    end else begin
      ready_q <= (st_q == DLT_I_IDLE) && !(accept && !bad);
      done_q  <= 1'h0;
      if (accept) begin
        rd_q      <= !req_write_i && !req_wake_i;
        rd_word_q <= req_word_i;
        if (bad || req_wake_i || cmd[CMD_NB_BIT]) begin
          done_q   <= 1'h1;
          err_q    <= bad;
          status_q <= 8'h00;
          rdata_q  <= 16'h0000;
        end
      end else if (end_beat && beat_q + 3'h1 == nall_q &&
                   nall_q != nreq_q) begin
        done_q   <= 1'h1;
        status_q <= rx_s2_q;
        err_q    <= !rx_s2_q[ST_EOT_BIT] || rx_s2_q[ST_ERR_BIT];
        if (rd_q) begin
          rdata_q <= {rd_word_q ? rx_q[1] : 8'h00, rx_q[0]};
        end
      end
    end
  end

  assign link.link_clk = clk_q;
  assign link.ini_data = dat_q;
  assign link.ini_oe   = oe_q;
  assign req_ready_o   = ready_q;
  assign done_o        = done_q;
  assign done_err_o    = err_q;
  assign done_rdata_o  = rdata_q;
  assign done_status_o = status_q;
  assign irq_o         = int_s2_q;

endmodule // dlt_initiator
`default_nettype wire

// File: dv/dlt_props.sv
// Checker on the die link wires shared by initiator and target
`timescale 1ns/1ps
`default_nettype none
module dlt_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       link_clk_i,
  input wire logic       link_int_i,
  input wire logic [7:0] tgt_data_i,
  input wire logic       tgt_oe_i,
  input wire logic [7:0] ini_data_i,
  input wire logic       ini_oe_i,
  input wire logic [7:0] link_data_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Link clock phases, four system cycles each
  sequence s_high;
    link_clk_i [*4] ##1 !link_clk_i;
  endsequence
  sequence s_low;
    !link_clk_i [*4];
  endsequence

  // ==========================================================
  // Wire rules
  a_one_driver: assert property (!(tgt_oe_i && ini_oe_i))
    else $error("both ends drive the data pins");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !link_clk_i && !ini_oe_i && !link_int_i)
    else $error("link not quiet after reset");
  a_high_phase: assert property ($rose(link_clk_i) |-> s_high)
    else $error("link clock high phase wrong");
  a_low_phase: assert property ($fell(link_clk_i) |-> s_low)
    else $error("link clock low phase too short");
  a_ini_hold: assert property (
    ini_oe_i && $past(ini_oe_i) && link_clk_i && $past(link_clk_i)
    |-> $stable(ini_data_i))
    else $error("initiator data moved while clock high");
  a_tgt_hold: assert property (
    tgt_oe_i && $past(tgt_oe_i) && link_clk_i && $past(link_clk_i)
    |-> $stable(tgt_data_i))
    else $error("target data moved while clock high");
  a_frame_start: assert property (
    $rose(ini_oe_i) |-> !link_clk_i ##[1:8] link_clk_i)
    else $error("frame start without clock low then high");
  a_turn_around: assert property (
    $rose(tgt_oe_i) |-> !ini_oe_i && !$past(ini_oe_i))
    else $error("target drove before initiator let go");
  a_pull_low: assert property (
    !tgt_oe_i && !ini_oe_i |-> link_data_i == 8'h00)
    else $error("released data pins not low");
endmodule // dlt_props
`default_nettype wire

// File: dv/tb_die_link_target_port.sv
// Bench joining both die link ends and checking transfers
`timescale 1ns/1ps
`default_nettype none
module tb_die_link_target_port;
  import dlt_pkg::*;
  logic        clk_i, rst_i;
  dlt_mode_t   mode;
  logic [3:0]  irq;
  logic        rq_v, rq_w, rq_wd, rq_wk;
  logic [15:0] rq_a, rq_d;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_word, reg_wr, reg_rd, wake;
  logic        ready, done, derr, irq_o;
  logic [15:0] drdata;
  logic [7:0]  dstat;
  logic [7:0]  mem [256];
  int          n_wr = 0;
  int          n_wake = 0;
  int          n_rd = 0;
  int          n_errors = 0;
  int          cmp_count = 0;

  dlt_link_if dlt_link_if_i ();

  dlt_target dlt_target_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(dlt_link_if_i), .mode_i(mode),
    .irq_i(irq), .reg_rdata_i({mem[reg_addr + 8'h01], mem[reg_addr]}),
    .reg_err_i(reg_addr == 8'h7e), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_word_o(reg_word), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .wake_o(wake));

  dlt_initiator dlt_initiator_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(dlt_link_if_i),
    .req_valid_i(rq_v),
    .req_write_i(rq_w), .req_word_i(rq_wd), .req_wake_i(rq_wk),
    .req_gaddr_i(rq_a), .req_wdata_i(rq_d), .req_ready_o(ready),
    .done_o(done), .done_err_o(derr), .done_rdata_o(drdata),
    .done_status_o(dstat), .irq_o(irq_o));

  dlt_props dlt_props_i (
    .clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(dlt_link_if_i.link_clk),
    .link_int_i(dlt_link_if_i.link_int),
    .tgt_data_i(dlt_link_if_i.tgt_data),
    .tgt_oe_i(dlt_link_if_i.tgt_oe),
    .ini_data_i(dlt_link_if_i.ini_data),
    .ini_oe_i(dlt_link_if_i.ini_oe),
    .link_data_i(dlt_link_if_i.link_data));

  // Analog register file behind the target, word writes low byte first
  always @(posedge clk_i) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata[7:0];
      if (reg_word) mem[reg_addr + 8'h01] <= reg_wdata[15:8];
      n_wr++;
    end
    if (wake) n_wake++;
    if (reg_rd) n_rd++;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One request: held until taken, then bounded wait for done
  task automatic req(input logic w, wd, wk, input logic [15:0] a, d);
    int k;
    @(negedge clk_i);
    {rq_w, rq_wd, rq_wk, rq_a, rq_d, rq_v} = {w, wd, wk, a, d, 1'b1};
    // Ready seen settled at a falling edge: the next rising edge takes it
    for (k = 0; k < 500 && ready !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i);
    rq_v = 1'b0;
    for (k = 0; k < 500 && done !== 1'b1; k++) @(negedge clk_i);
    chk("done", {15'h0, done}, 16'h1);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial begin
    int k, w0;
    logic [7:0] bnd [2];
    bnd = '{8'h00, 8'hff};
    {rst_i, mode, irq} = {1'b1, DLT_MODE_NORMAL, 4'h0};
    {rq_v, rq_w, rq_wd, rq_wk, rq_a, rq_d} = '0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    idle(25);
    req(1, 0, 0, 16'h0210, 16'h005a);
    chk("st_wr", {8'h0, dstat}, 16'h0083);
    chk("wr_a", {8'h0, reg_addr}, 16'h0010);
    chk("wr_d", {8'h0, reg_wdata[7:0]}, 16'h005a);
    req(1, 1, 0, 16'h0220, 16'hbeef);
    chk("wr_w", reg_wdata, 16'hbeef);
    w0 = n_rd;
    req(0, 0, 0, 16'h0210, 16'h0);
    chk("rd_strb", 16'(n_rd - w0), 16'h1);
    chk("rd_b", {8'h0, drdata[7:0]}, 16'h005a);
    chk("st_rd", {8'h0, dstat}, 16'h0081);
    req(0, 1, 0, 16'h0220, 16'h0);
    chk("rd_w", drdata, 16'hbeef);
    for (int i = 0; i < 2; i++) begin
      req(1, 0, 0, {8'h02, bnd[i]}, {8'h0, ~bnd[i]});
      req(0, 0, 0, {8'h02, bnd[i]}, 16'h0);
      chk("edge", {8'h0, drdata[7:0]}, {8'h0, ~bnd[i]});
    end
    w0 = n_wr;
    req(1, 0, 0, 16'h0330, 16'h003c);
    chk("nb_err", {15'h0, derr}, 16'h0);
    for (k = 0; k < 300 && n_wr == w0; k++) @(negedge clk_i);
    chk("nb_a", {8'h0, reg_addr}, 16'h0030);
    chk("nb_d", {8'h0, reg_wdata[7:0]}, 16'h003c);
    w0 = n_wr;
    req(0, 0, 0, 16'h0310, 16'h0);
    chk("rd_nb", {15'h0, derr}, 16'h1);
    req(1, 0, 0, 16'h0410, 16'h0011);
    chk("bad_pg", {15'h0, derr}, 16'h1);
    chk("no_frame", 16'(n_wr - w0), 16'h0);
    req(0, 0, 0, 16'h027e, 16'h0);
    chk("st_err", {14'h0, dstat[7:6]}, 16'h3);
    // Interrupt path has three cycles of latency end to end
    irq = 4'h4;
    idle(4);
    chk("irq_on", {15'h0, irq_o}, 16'h1);
    irq = 4'h0;
    idle(4);
    chk("irq_off", {15'h0, irq_o}, 16'h0);
    {mode, irq} = {DLT_MODE_SLEEP, 4'h1};
    idle(4);
    chk("sl_irq", {15'h0, irq_o}, 16'h0);
    chk("sl_oe", {15'h0, dlt_link_if_i.tgt_oe}, 16'h1);
    chk("sl_pin", {8'h0, dlt_link_if_i.link_data}, 16'h0);
    mode = DLT_MODE_STOP;
    idle(4);
    chk("sp_irq", {15'h0, irq_o}, 16'h1);
    irq = 4'h0;
    w0 = n_wr;
    req(1, 0, 0, 16'h0240, 16'h0077);
    chk("sp_nowr", 16'(n_wr - w0), 16'h0);
    chk("sp_eot", {15'h0, dstat[7]}, 16'h0);
    w0 = n_wake;
    req(0, 0, 1, 16'h0200, 16'h0);
    for (k = 0; k < 300 && n_wake == w0; k++) @(negedge clk_i);
    chk("wake", 16'(n_wake - w0), 16'h1);
    idle(40);
    mode = DLT_MODE_NORMAL;
    idle(25);
    req(1, 0, 0, 16'h0240, 16'h0099);
    req(0, 0, 0, 16'h0240, 16'h0);
    chk("resync", {8'h0, drdata[7:0]}, 16'h0099);
    final_report();
  end
endmodule // tb_die_link_target_port
`default_nettype wire
